// ==== include/bmc_select_regs.svh ====
`ifndef BMC_SELECT_REGS_SVH
`define BMC_SELECT_REGS_SVH

// ****************************************
// local selection data set defaults
// ****************************************
`define LOCAL_PRIO1        8'h80
`define LOCAL_GRADE        8'hF8
`define LOCAL_PRECISION    8'hFE
`define LOCAL_VARIANCE     16'hFFFF
`define LOCAL_PRIO2_FAST   8'h7A
`define LOCAL_PRIO2_SLOW   8'h80

// ****************************************
// message type codes (low nibble of header)
// ****************************************
`define MSG_SYNC           4'h0
`define MSG_DELAY_REQ      4'h1
`define MSG_PDELAY_REQ     4'h2
`define MSG_PDELAY_RESP    4'h3
`define MSG_FOLLOW_UP      4'h8
`define MSG_DELAY_RESP     4'h9
`define MSG_PDELAY_RESP_FU 4'hA
`define MSG_ANNOUNCE       4'hB
`define MSG_SIGNALING      4'hC
`define MSG_MANAGEMENT     4'hD

// ****************************************
// best foreign data set hold time
// ****************************************
`define ANNOUNCE_TIMEOUT_US 1000
`define CLK_MHZ             100

`endif

// ==== include/bmc_select_pkg.sv ====
package bmc_select_pkg;

    typedef enum logic [1:0]
    {
        CLASS_EVENT,
        CLASS_GENERAL,
        CLASS_RESERVED
    } msg_class_e;

    typedef enum logic [2:0]
    {
        USE_TIME_XFER,
        USE_LINK_DELAY,
        USE_ANNOUNCE,
        USE_MANAGEMENT,
        USE_SIGNALING,
        USE_NONE
    } msg_use_e;

    typedef enum logic [1:0]
    {
        PORT_LISTENING,
        PORT_MASTER,
        PORT_SLAVE
    } port_state_e;

endpackage : bmc_select_pkg

// ==== verilog/data_set_compare.sv ====
`timescale 1ns/100ps
`include "bmc_select_regs.svh"

// ****************************************
// ordered data set comparison
// ****************************************
module data_set_compare
(
    input  wire logic [7:0]  a_prio1_in,
    input  wire logic [7:0]  a_grade_in,
    input  wire logic [7:0]  a_precision_in,
    input  wire logic [15:0] a_variance_in,
    input  wire logic [7:0]  a_prio2_in,
    input  wire logic [63:0] a_ident_in,
    input  wire logic [7:0]  b_prio1_in,
    input  wire logic [7:0]  b_grade_in,
    input  wire logic [7:0]  b_precision_in,
    input  wire logic [15:0] b_variance_in,
    input  wire logic [7:0]  b_prio2_in,
    input  wire logic [63:0] b_ident_in,
    output logic             a_better_out
);

    // first differing field decides, smaller wins
    always_comb
    begin
        if (a_prio1_in != b_prio1_in)
            a_better_out = a_prio1_in < b_prio1_in;
        else if (a_grade_in != b_grade_in)
            a_better_out = a_grade_in < b_grade_in;
        else if (a_precision_in != b_precision_in)
            a_better_out = a_precision_in < b_precision_in;
        else if (a_variance_in != b_variance_in)
            a_better_out = a_variance_in < b_variance_in;
        else if (a_prio2_in != b_prio2_in)
            a_better_out = a_prio2_in < b_prio2_in;
        else
            a_better_out = a_ident_in < b_ident_in;
    end

endmodule : data_set_compare

// ==== verilog/best_master_clock_select.sv ====
`timescale 1ns/100ps
`include "bmc_select_regs.svh"

// How it works
// - rank by priority1, grade, precision, variance, priority2, then identifier
// - smaller value wins; first differing field decides
// - local set advertises 128, 248, FE, FFFF
// - fast units advertise priority2 122 instead of 128
// - both priority fields are 8-bit unsigned
// - quality given by grade and precision fields, no stratum
// - identifier built from the unit's MAC address
// - Sync, Delay_Req, Pdelay_Req, Pdelay_Resp are event messages, timestamped
// - Announce, Follow_Up, Delay_Resp, Pdelay_Resp_Follow_Up are general
// - Management and Signaling are general, no timestamp
// - announce data sets feed the selection of the grandmaster
// - peer delay messages only drive link delay measurement
module best_master_clock_select
    import bmc_select_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `ANNOUNCE_TIMEOUT_US * `CLK_MHZ
)
(
    input  wire logic                        clock_in,
    input  wire logic                        sys_rst_in,
    input  wire logic                        fast_unit_in,
    input  wire logic [47:0]                 mac_addr_in,
    input  wire logic                        msg_valid_in,
    input  wire logic [3:0]                  msg_type_in,
    input  wire logic                        ann_valid_in,
    input  wire logic [7:0]                  ann_prio1_in,
    input  wire logic [7:0]                  ann_grade_in,
    input  wire logic [7:0]                  ann_precision_in,
    input  wire logic [15:0]                 ann_variance_in,
    input  wire logic [7:0]                  ann_prio2_in,
    input  wire logic [63:0]                 ann_ident_in,
    output logic                             ts_capture_out,
    output bmc_select_pkg::msg_class_e       msg_class_out,
    output bmc_select_pkg::msg_use_e         msg_use_out,
    output logic                             class_valid_out,
    output logic                             link_delay_out,
    output bmc_select_pkg::port_state_e      port_state_out,
    output logic                             local_is_master_out,
    output logic [7:0]                       best_prio1_out,
    output logic [7:0]                       best_grade_out,
    output logic [7:0]                       best_precision_out,
    output logic [15:0]                      best_variance_out,
    output logic [7:0]                       best_prio2_out,
    output logic [63:0]                      best_ident_out,
    output logic [7:0]                       local_prio2_out,
    output logic [63:0]                      local_ident_out
);
    import bmc_select_pkg::*;

    localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);

    // ****************************************
    // local data set
    // ****************************************
    logic [7:0]  local_prio2;
    logic [63:0] local_ident;

    // EUI-64 style identifier from MAC
    function automatic logic [63:0] mac_to_ident(input logic [47:0] mac);
        mac_to_ident = {mac[47:24], 16'hFFFE, mac[23:0]};
    endfunction : mac_to_ident

    assign local_prio2 = fast_unit_in ? `LOCAL_PRIO2_FAST : `LOCAL_PRIO2_SLOW;
    assign local_ident = mac_to_ident(mac_addr_in);

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            local_prio2_out <= `LOCAL_PRIO2_SLOW;
            local_ident_out <= 64'h0;
        end
        else
        begin
            local_prio2_out <= local_prio2;
            local_ident_out <= local_ident;
        end
    end

    // ****************************************
    // message classification
    // ****************************************
    msg_class_e cls_d;
    msg_use_e   use_d;

    always_comb
    begin
        cls_d = CLASS_RESERVED;
        use_d = USE_NONE;
        unique case (msg_type_in)
            `MSG_SYNC, `MSG_DELAY_REQ:
            begin
                cls_d = CLASS_EVENT;
                use_d = USE_TIME_XFER;
            end
            `MSG_PDELAY_REQ, `MSG_PDELAY_RESP:
            begin
                cls_d = CLASS_EVENT;
                use_d = USE_LINK_DELAY;
            end
            `MSG_FOLLOW_UP, `MSG_DELAY_RESP:
            begin
                cls_d = CLASS_GENERAL;
                use_d = USE_TIME_XFER;
            end
            `MSG_PDELAY_RESP_FU:
            begin
                cls_d = CLASS_GENERAL;
                use_d = USE_LINK_DELAY;
            end
            `MSG_ANNOUNCE:
            begin
                cls_d = CLASS_GENERAL;
                use_d = USE_ANNOUNCE;
            end
            `MSG_MANAGEMENT:
            begin
                cls_d = CLASS_GENERAL;
                use_d = USE_MANAGEMENT;
            end
            `MSG_SIGNALING:
            begin
                cls_d = CLASS_GENERAL;
                use_d = USE_SIGNALING;
            end
            default:
            begin
                cls_d = CLASS_RESERVED;
                use_d = USE_NONE;
            end
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            msg_class_out   <= CLASS_RESERVED;
            msg_use_out     <= USE_NONE;
            class_valid_out <= 1'b0;
            ts_capture_out  <= 1'b0;
            link_delay_out  <= 1'b0;
        end
        else
        begin
            class_valid_out <= msg_valid_in;
            ts_capture_out  <= msg_valid_in && (cls_d == CLASS_EVENT);
            link_delay_out  <= msg_valid_in && (use_d == USE_LINK_DELAY);
            if (msg_valid_in)
            begin
                msg_class_out <= cls_d;
                msg_use_out   <= use_d;
            end
        end
    end

    // ****************************************
    // best foreign data set
    // ****************************************
    logic [7:0]  best_prio1_q;
    logic [7:0]  best_grade_q;
    logic [7:0]  best_precision_q;
    logic [15:0] best_variance_q;
    logic [7:0]  best_prio2_q;
    logic [63:0] best_ident_q;
    logic        best_known_q;
    logic        ann_beats_best;
    logic        local_beats_best;
    logic        ann_is_announce;
    logic        refresh_same;
    logic [CNT_W-1:0] age_q;

    assign ann_is_announce = ann_valid_in;
    assign refresh_same    = best_known_q && (ann_ident_in == best_ident_q);

    data_set_compare u_ann_vs_best
    (
        .a_prio1_in     (ann_prio1_in),
        .a_grade_in     (ann_grade_in),
        .a_precision_in (ann_precision_in),
        .a_variance_in  (ann_variance_in),
        .a_prio2_in     (ann_prio2_in),
        .a_ident_in     (ann_ident_in),
        .b_prio1_in     (best_prio1_q),
        .b_grade_in     (best_grade_q),
        .b_precision_in (best_precision_q),
        .b_variance_in  (best_variance_q),
        .b_prio2_in     (best_prio2_q),
        .b_ident_in     (best_ident_q),
        .a_better_out   (ann_beats_best)
    );

    data_set_compare u_local_vs_best
    (
        .a_prio1_in     (`LOCAL_PRIO1),
        .a_grade_in     (`LOCAL_GRADE),
        .a_precision_in (`LOCAL_PRECISION),
        .a_variance_in  (`LOCAL_VARIANCE),
        .a_prio2_in     (local_prio2),
        .a_ident_in     (local_ident),
        .b_prio1_in     (best_prio1_q),
        .b_grade_in     (best_grade_q),
        .b_precision_in (best_precision_q),
        .b_variance_in  (best_variance_q),
        .b_prio2_in     (best_prio2_q),
        .b_ident_in     (best_ident_q),
        .a_better_out   (local_beats_best)
    );

    // keep the best foreign set; same source refreshes it; forget on timeout
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            best_known_q     <= 1'b0;
            best_prio1_q     <= 8'hFF;
            best_grade_q     <= 8'hFF;
            best_precision_q <= 8'hFF;
            best_variance_q  <= 16'hFFFF;
            best_prio2_q     <= 8'hFF;
            best_ident_q     <= 64'hFFFF_FFFF_FFFF_FFFF;
            age_q            <= '0;
        end
        else if (ann_is_announce && (!best_known_q || refresh_same || ann_beats_best))
        begin
            best_known_q     <= 1'b1;
            best_prio1_q     <= ann_prio1_in;
            best_grade_q     <= ann_grade_in;
            best_precision_q <= ann_precision_in;
            best_variance_q  <= ann_variance_in;
            best_prio2_q     <= ann_prio2_in;
            best_ident_q     <= ann_ident_in;
            age_q            <= '0;
        end
        else if (best_known_q)
        begin
            if (age_q == CNT_W'(TIMEOUT_CYCLES))
                best_known_q <= 1'b0;
            else
                age_q <= age_q + 1'b1;
        end
    end

    // ****************************************
    // port state
    // ****************************************
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            port_state_out      <= PORT_LISTENING;
            local_is_master_out <= 1'b0;
        end
        else if (!best_known_q || local_beats_best)
        begin
            port_state_out      <= PORT_MASTER;
            local_is_master_out <= 1'b1;
        end
        else
        begin
            port_state_out      <= PORT_SLAVE;
            local_is_master_out <= 1'b0;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            best_prio1_out     <= `LOCAL_PRIO1;
            best_grade_out     <= `LOCAL_GRADE;
            best_precision_out <= `LOCAL_PRECISION;
            best_variance_out  <= `LOCAL_VARIANCE;
            best_prio2_out     <= `LOCAL_PRIO2_SLOW;
            best_ident_out     <= 64'h0;
        end
        else if (!best_known_q || local_beats_best)
        begin
            best_prio1_out     <= `LOCAL_PRIO1;
            best_grade_out     <= `LOCAL_GRADE;
            best_precision_out <= `LOCAL_PRECISION;
            best_variance_out  <= `LOCAL_VARIANCE;
            best_prio2_out     <= local_prio2;
            best_ident_out     <= local_ident;
        end
        else
        begin
            best_prio1_out     <= best_prio1_q;
            best_grade_out     <= best_grade_q;
            best_precision_out <= best_precision_q;
            best_variance_out  <= best_variance_q;
            best_prio2_out     <= best_prio2_q;
            best_ident_out     <= best_ident_q;
        end
    end

endmodule : best_master_clock_select

// ==== verif/bmc_select_properties.sv ====
`timescale 1ns/100ps

// ********
// selector port checks
// ********
module bmc_select_properties
    import bmc_select_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = 20
)
(
    input wire logic                   clock_in,
    input wire logic                   sys_rst_in,
    input wire logic                   fast_unit_in,
    input wire logic [47:0]            mac_addr_in,
    input wire logic                   msg_valid_in,
    input wire logic [3:0]             msg_type_in,
    input wire logic                   ann_valid_in,
    input wire logic [7:0]             ann_prio1_in,
    input wire logic                   ts_capture_out,
    input wire bmc_select_pkg::msg_class_e msg_class_out,
    input wire logic                   class_valid_out,
    input wire logic                   link_delay_out,
    input wire bmc_select_pkg::port_state_e port_state_out,
    input wire logic                   local_is_master_out,
    input wire logic [7:0]             best_prio1_out,
    input wire logic [7:0]             best_grade_out,
    input wire logic [7:0]             best_precision_out,
    input wire logic [15:0]            best_variance_out,
    input wire logic [7:0]             local_prio2_out,
    input wire logic [63:0]            local_ident_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);

    AST_TS_EVENT:
    assert property (msg_valid_in && msg_type_in inside {4'h0, 4'h1, 4'h2, 4'h3}
        |=> ts_capture_out && msg_class_out == CLASS_EVENT) else $error("event not stamped");
    AST_GENERAL:
    assert property (msg_valid_in && msg_type_in inside {4'h8, 4'h9, 4'hA, 4'hB}
        |=> !ts_capture_out && msg_class_out == CLASS_GENERAL) else $error("general wrong");
    AST_MGMT_SIG:
    assert property (msg_valid_in && msg_type_in inside {4'hC, 4'hD}
        |=> !ts_capture_out && msg_class_out == CLASS_GENERAL) else $error("mgmt wrong");
    AST_PEER_ONLY:
    assert property (link_delay_out |-> $past(msg_valid_in)
        && $past(msg_type_in) inside {4'h2, 4'h3, 4'hA}) else $error("stray link delay");
    AST_CLASS_PULSE:
    assert property (!$past(sys_rst_in) |-> class_valid_out == $past(msg_valid_in))
        else $error("class pulse");
    AST_ANN_WIN:
    assert property (ann_valid_in && ann_prio1_in < best_prio1_out
        |-> ##2 port_state_out == PORT_SLAVE && !local_is_master_out) else $error("no slave");
    AST_MASTER_SET:
    assert property (local_is_master_out |-> best_prio1_out == 8'h80
        && best_grade_out == 8'hF8 && best_precision_out == 8'hFE
        && best_variance_out == 16'hFFFF) else $error("local set wrong");
    AST_PRIO2:
    assert property (!$past(sys_rst_in) |-> local_prio2_out
        == ($past(fast_unit_in) ? 8'h7A : 8'h80)) else $error("prio2 wrong");
    AST_IDENT:
    assert property (!$past(sys_rst_in) |-> local_ident_out
        == {mac_addr_in[47:24], 16'hFFFE, mac_addr_in[23:0]}) else $error("ident wrong");
    AST_MASTER_STATE:
    assert property (local_is_master_out == (port_state_out == PORT_MASTER))
        else $error("state mismatch");
endmodule : bmc_select_properties

bind best_master_clock_select bmc_select_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props
    (.clock_in, .sys_rst_in, .fast_unit_in, .mac_addr_in, .msg_valid_in, .msg_type_in,
     .ann_valid_in, .ann_prio1_in, .ts_capture_out, .msg_class_out, .class_valid_out,
     .link_delay_out, .port_state_out, .local_is_master_out, .best_prio1_out,
     .best_grade_out, .best_precision_out, .best_variance_out, .local_prio2_out,
     .local_ident_out);

// ==== verif/remote_clock_model.sv ====
`timescale 1ns/100ps

// ********
// other network clocks
// ********
module remote_clock_model
(
    input  wire logic   clock_in,
    output logic        msg_valid_out,
    output logic [3:0]  msg_type_out,
    output logic        ann_valid_out,
    output logic [7:0]  p1_out,
    output logic [7:0]  grade_out,
    output logic [7:0]  prec_out,
    output logic [15:0] var_out,
    output logic [7:0]  p2_out,
    output logic [63:0] id_out
);
    initial
    begin
        msg_valid_out = 1'b0;
        msg_type_out = 4'h0;
        ann_valid_out = 1'b0;
        {p1_out, grade_out, prec_out, var_out, p2_out, id_out} = '0;
    end

    task automatic send_msg(input logic [3:0] code);
        @(negedge clock_in);
        msg_valid_out <= 1'b1;
        msg_type_out <= code;
    endtask : send_msg

    task automatic msg_idle();
        @(negedge clock_in);
        msg_valid_out <= 1'b0;
        msg_type_out <= ~msg_type_out;
    endtask : msg_idle

    // announce pulse, then fields scrambled
    task automatic send_ann(input logic [63:0] f [6]);
        @(negedge clock_in);
        ann_valid_out <= 1'b1;
        {p1_out, grade_out, prec_out} <= {f[0][7:0], f[1][7:0], f[2][7:0]};
        {var_out, p2_out, id_out} <= {f[3][15:0], f[4][7:0], f[5]};
        @(negedge clock_in);
        ann_valid_out <= 1'b0;
        {p1_out, grade_out, prec_out, var_out, p2_out, id_out} <=
            ~{p1_out, grade_out, prec_out, var_out, p2_out, id_out};
    endtask : send_ann
endmodule : remote_clock_model

// ==== verif/best_master_clock_select_tb_top.sv ====
`timescale 1ns/100ps

// ********
// selector bench
// ********
module best_master_clock_select_tb_top;
    import bmc_select_pkg::*;

    logic        clock_in, sys_rst_in, fast_unit_in, msg_valid, ann_valid;
    logic [47:0] mac_addr;
    logic [3:0]  msg_type;
    logic [7:0]  a_p1, a_grade, a_prec, a_p2, b_p1, b_grade, b_prec, b_p2, loc_p2;
    logic [15:0] a_var, b_var;
    logic [63:0] a_id, b_id, loc_id;
    logic        ts_cap, cls_valid, link_dly, is_master;
    msg_class_e  cls;
    msg_use_e    use_kind;
    port_state_e state;
    logic [63:0] loc [6];
    logic [63:0] f [6];
    int          fail_count = 0;
    int          checks_done = 0;

    best_master_clock_select #(.TIMEOUT_CYCLES(20)) dut
    (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .fast_unit_in(fast_unit_in),
        .mac_addr_in(mac_addr), .msg_valid_in(msg_valid), .msg_type_in(msg_type),
        .ann_valid_in(ann_valid), .ann_prio1_in(a_p1), .ann_grade_in(a_grade),
        .ann_precision_in(a_prec), .ann_variance_in(a_var), .ann_prio2_in(a_p2),
        .ann_ident_in(a_id), .ts_capture_out(ts_cap), .msg_class_out(cls),
        .msg_use_out(use_kind), .class_valid_out(cls_valid), .link_delay_out(link_dly),
        .port_state_out(state), .local_is_master_out(is_master), .best_prio1_out(b_p1),
        .best_grade_out(b_grade), .best_precision_out(b_prec), .best_variance_out(b_var),
        .best_prio2_out(b_p2), .best_ident_out(b_id), .local_prio2_out(loc_p2),
        .local_ident_out(loc_id)
    );

    remote_clock_model partner
    (
        .clock_in(clock_in), .msg_valid_out(msg_valid), .msg_type_out(msg_type),
        .ann_valid_out(ann_valid), .p1_out(a_p1), .grade_out(a_grade), .prec_out(a_prec),
        .var_out(a_var), .p2_out(a_p2), .id_out(a_id)
    );

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic check_set(input logic win);
        logic [63:0] seen [6];
        seen = '{b_p1, b_grade, b_prec, b_var, b_p2, b_id};
        check(state, win ? PORT_SLAVE : PORT_MASTER);
        check(is_master, !win);
        for (int j = 0; j < 6; j++)
            check(seen[j], win ? f[j] : loc[j]);
    endtask : check_set

    task automatic do_reset(input logic fast);
        @(negedge clock_in);
        sys_rst_in = 1'b1;
        fast_unit_in = fast;
        loc = '{8'h80, 8'hF8, 8'hFE, 16'hFFFF, fast ? 8'h7A : 8'h80,
                {mac_addr[47:24], 16'hFFFE, mac_addr[23:0]}};
        repeat (16) @(negedge clock_in);
        sys_rst_in = 1'b0;
        repeat (3) @(negedge clock_in);
        check(loc_p2, loc[4]);
        check(loc_id, loc[5]);
        check_set(1'b0);
    endtask : do_reset

    task automatic ann_case(input logic win);
        partner.send_ann(f);
        repeat (2) @(negedge clock_in);
        check_set(win);
    endtask : ann_case

    task automatic test_classify();
        logic [11:0] tbl [11] = '{12'h080, 12'h180, 12'h2C1, 12'h3C1, 12'h810, 12'h910,
                                  12'hA51, 12'hB12, 12'hC14, 12'hD13, 12'h525};
        for (int i = 0; i < 12; i++)
        begin
            if (i < 11)
                partner.send_msg(tbl[i][11:8]);
            else
                partner.msg_idle();
            if (i > 0)
            begin
                check(cls_valid, 1'b1);
                check(ts_cap, tbl[i - 1][7]);
                check(link_dly, tbl[i - 1][6]);
                check(cls, tbl[i - 1][5:4]);
                check(use_kind, tbl[i - 1][2:0]);
            end
        end
    endtask : test_classify

    // smaller field k wins though later fields are worse
    task automatic test_ranking();
        logic [63:0] ones [6] = '{64'hFF, 64'hFF, 64'hFF, 64'hFFFF, 64'hFF,
                                  64'hFFFF_FFFF_FFFF_FFFF};
        for (int k = 0; k < 6; k++)
            for (int w = 0; w < 2; w++)
                if (w == 1 || k != 3)
                begin
                    do_reset(1'b0);
                    for (int j = 0; j < 6; j++)
                        f[j] = (j < k) ? loc[j] : (j > k) ? (w == 1 ? ones[j] : 64'h0)
                             : (w == 1 ? loc[j] - 64'h1 : loc[j] + 64'h1);
                    ann_case(w == 1);
                end
    endtask : test_ranking

    task automatic test_fast();
        do_reset(1'b1);
        f = loc;
        f[4] = 64'h80;
        f[5] = 64'h0;
        ann_case(1'b0);
        f[4] = 64'h79;
        ann_case(1'b1);
        // other source, worse only by identifier: must be ignored
        f[5] = 64'h1;
        partner.send_ann(f);
        f[5] = 64'h0;
        repeat (2) @(negedge clock_in);
        check_set(1'b1);
        // no refresh: stored set ages out, local set takes over
        repeat (25) @(negedge clock_in);
        check_set(1'b0);
    endtask : test_fast

    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    initial
    begin
        sys_rst_in = 1'b1;
        fast_unit_in = 1'b0;
        mac_addr = 48'h0212_3456_789A;
        do_reset(1'b0);
        test_classify();
        test_ranking();
        test_fast();
        end_sim();
    end

    initial
    begin
        repeat (5000) @(posedge clock_in);
        fail_count++;
        end_sim();
    end
endmodule : best_master_clock_select_tb_top
